// ### logic/ppmf_defs.vh
`ifndef PPMF_DEFS_VH
`define PPMF_DEFS_VH

// Register byte addresses
`define PPMF_ADR_PORT_DATA      32'hFFFFF00C
`define PPMF_ADR_PORT_DIR       32'hFFFFF02C
`define PPMF_ADR_HOLD_WAIT_MODE 32'hFFFFF04C
`define PPMF_ADR_TA_FILT_SEL    32'h0FFFF5F8
`define PPMF_ADR_TC_FILT_SEL    32'hFFFFF698
`define PPMF_ADR_TIMER_PIN_MODE 32'hFFFFF6A0
`define PPMF_ADR_BIT_OP         32'hFFFFF6A4

// Reset values
`define PPMF_RST_MODE_SINGLE0   4'h0
`define PPMF_RST_MODE_EXPANDED  4'hF
`define PPMF_RST_PORT_DIR       5'h1F
`define PPMF_RST_FILT_SEL       2'h0

// Hold/wait mode control bit positions
`define PPMF_BIT_WAIT_SEL       0
`define PPMF_BIT_SYSTEM_CLOCK_OUTPUT_SEL     1
`define PPMF_BIT_HOLD_ACK_SEL   2
`define PPMF_BIT_HOLD_REQ_SEL   3

// Bit operation register fields
`define PPMF_BITOP_OP_LSB       8
`define PPMF_BITOP_TARGET_BIT   12
`define PPMF_OP_SET             2'h1
`define PPMF_OP_CLEAR           2'h2
`define PPMF_OP_INVERT          2'h3

// Filter acceptance count in sampling clocks
`define PPMF_FILT_SAMPLES       3'h4

`endif

// ### logic/ppmf_top.v
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`include "ppmf_defs.vh"

module ppmf_top
(
  // Clock and reset
  input  wire        mclk_in,
  input  wire        srst_in,
  input  wire        expanded_mode_strap_in,

  // Wishbone slave
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [31:0] wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,

  // Port pins
  input  wire [4:0]  port_pin_in,
  output reg  [4:0]  port_pin_out,
  output reg  [4:0]  port_pin_oe_out,

  // Bus control alternate functions
  input  wire        bus_hold_acknowledge_in,
  output reg         wait_request_out,
  output reg         bus_hold_request_out,

  // Interrupt pins, analog filtered in the pad
  input  wire [7:0]  external_interrupt_input_in,
  input  wire [7:0]  interrupt_ctrl_mode_in,
  output wire [7:0]  external_interrupt_out,

  // Timer inputs and prescaler ticks
  input  wire        timer_ab_prescaler_clock_in,
  input  wire        timer_c_prescaler_clock_in,
  input  wire [2:0]  timer_a_pin_in,
  input  wire [1:0]  timer_c_pin_in,
  output reg  [2:0]  timer_a_filtered_out,
  output reg  [1:0]  timer_c_filtered_out
);

  // Register state
  reg  [4:0]  port_data_reg;
  reg  [4:0]  port_data_next;
  reg  [4:0]  port_dir_reg;
  reg  [3:0]  hold_wait_mode_reg;
  reg  [1:0]  ta_filt_sel_reg;
  reg  [1:0]  ta_filt_sel_next;
  reg  [3:0]  tc_filt_sel_reg;
  reg  [4:0]  timer_pin_mode_reg;

  // Clock out divider and prescaler phase counters
  reg         clk_div_reg;
  reg  [2:0]  ta_presc_cnt_reg;
  reg  [7:0]  tc_presc_cnt_reg;

  // Filter state, one counter per channel
  reg  [4:0]  filt_level_reg;
  reg  [2:0]  filt_cnt_reg [0:4];
  reg  [4:0]  filt_accept;

  // Combinational helpers
  reg  [4:0]  alt_out;
  reg  [4:0]  port_readback;
  reg  [4:0]  ta_op_val;
  reg  [4:0]  samp_tick;
  reg  [4:0]  raw_in;
  reg  [31:0] rd_data;

  // Bus decode
  wire        bus_req;
  wire        wr_req;
  wire        wr_port_data;
  wire        wr_port_dir;
  wire        wr_hold_wait_mode;
  wire        wr_ta_filt_sel;
  wire        wr_tc_filt_sel;
  wire        wr_timer_pin_mode;
  wire        wr_bit_op;
  wire [1:0]  bit_op;
  integer     k;
  integer     m;

  // True on a prescaler tick when the low n bits of the count are all ones
  function div_tick;
    input       presc;
    input [7:0] cnt;
    input [3:0] n;
    reg   [7:0] mask;
    begin
      mask = (8'h01 << n) - 8'h01;
      div_tick = presc & ((cnt & mask) == mask);
    end
  endfunction

  // Applies a set, clear or invert op to a value under a mask
  function [4:0] apply_op;
    input [4:0] val;
    input [4:0] mask;
    input [1:0] op;
    begin
      case (op)
        `PPMF_OP_SET:    apply_op = val | mask;
        `PPMF_OP_CLEAR:  apply_op = val & ~mask;
        `PPMF_OP_INVERT: apply_op = val ^ mask;
        default:         apply_op = val;
      endcase
    end
  endfunction

  // A write lands at the edge where the master sees ack, never earlier
  assign bus_req           = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_req            = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & wb_sel_in[0];
  assign wr_port_data      = wr_req & (wb_adr_in == `PPMF_ADR_PORT_DATA);
  assign wr_port_dir       = wr_req & (wb_adr_in == `PPMF_ADR_PORT_DIR);
  assign wr_hold_wait_mode = wr_req & (wb_adr_in == `PPMF_ADR_HOLD_WAIT_MODE);
  assign wr_ta_filt_sel    = wr_req & (wb_adr_in == `PPMF_ADR_TA_FILT_SEL);
  assign wr_tc_filt_sel    = wr_req & (wb_adr_in == `PPMF_ADR_TC_FILT_SEL);
  assign wr_timer_pin_mode = wr_req & (wb_adr_in == `PPMF_ADR_TIMER_PIN_MODE);
  assign wr_bit_op         = wr_req & (wb_adr_in == `PPMF_ADR_BIT_OP);
  assign bit_op            = wb_dat_in[`PPMF_BITOP_OP_LSB+1:`PPMF_BITOP_OP_LSB];

  // Alternate-function outputs per pin; input-only functions read as zero
  always @*
  begin
    alt_out    = 5'h00;
    alt_out[1] = clk_div_reg;
    alt_out[2] = bus_hold_acknowledge_in;
  end

  // Readback of the port data register; latch unless overridden below
  always @*
  begin
    port_readback = port_data_reg;

    if (port_dir_reg[0])
      port_readback[0] = port_pin_in[0];
    else if (hold_wait_mode_reg[`PPMF_BIT_WAIT_SEL])
      port_readback[0] = alt_out[0];

    if (port_dir_reg[1])
      port_readback[1] = port_pin_in[1];
    else if (hold_wait_mode_reg[`PPMF_BIT_SYSTEM_CLOCK_OUTPUT_SEL])
      port_readback[1] = alt_out[1];

    if (port_dir_reg[2])
      port_readback[2] = port_pin_in[2];
    else if (hold_wait_mode_reg[`PPMF_BIT_HOLD_ACK_SEL])
      port_readback[2] = alt_out[2];

    if (port_dir_reg[3])
      port_readback[3] = port_pin_in[3];
    else if (hold_wait_mode_reg[`PPMF_BIT_HOLD_REQ_SEL])
      port_readback[3] = alt_out[3];

    // Pin 4 has no control mode
    if (port_dir_reg[4])
      port_readback[4] = port_pin_in[4];
  end

  // Latch and select updates, plain writes and bit ops
  always @*
  begin
    port_data_next   = port_data_reg;
    ta_filt_sel_next = ta_filt_sel_reg;
    ta_op_val        = apply_op({3'h0, ta_filt_sel_reg}, wb_dat_in[4:0], bit_op);
    if (wr_port_data)
      port_data_next = wb_dat_in[4:0];
    else if (wr_ta_filt_sel)
      ta_filt_sel_next = wb_dat_in[1:0];
    else if (wr_bit_op)
    begin
      // Whole port is rewritten, so input bits take the pin level
      if (wb_dat_in[`PPMF_BITOP_TARGET_BIT])
        ta_filt_sel_next = ta_op_val[1:0];
      else
        port_data_next = apply_op(port_readback, wb_dat_in[4:0], bit_op);
    end
  end

  // Register read mux; unmapped reads return zero
  always @*
  begin
    case (wb_adr_in)
      `PPMF_ADR_PORT_DATA:      rd_data = {27'h0, port_readback};
      `PPMF_ADR_PORT_DIR:       rd_data = {27'h0, port_dir_reg};
      // Upper mode bits are not stored, so they read zero
      `PPMF_ADR_HOLD_WAIT_MODE: rd_data = {28'h0, hold_wait_mode_reg};
      `PPMF_ADR_TA_FILT_SEL:    rd_data = {30'h0, ta_filt_sel_reg};
      `PPMF_ADR_TC_FILT_SEL:    rd_data = {28'h0, tc_filt_sel_reg};
      `PPMF_ADR_TIMER_PIN_MODE: rd_data = {27'h0, timer_pin_mode_reg};
      default:                  rd_data = 32'h00000000;
    endcase
  end

  // Register file and bus answer, one cycle after the request
  always @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      wb_ack_out         <= 1'b0;
      wb_dat_out         <= 32'h00000000;
      port_data_reg      <= 5'h00;
      port_dir_reg       <= `PPMF_RST_PORT_DIR;
      ta_filt_sel_reg    <= `PPMF_RST_FILT_SEL;
      tc_filt_sel_reg    <= 4'h0;
      timer_pin_mode_reg <= 5'h00;
      // Strap sampled while reset is held, clocked like all else
      if (expanded_mode_strap_in)
        hold_wait_mode_reg <= `PPMF_RST_MODE_EXPANDED;
      else
        hold_wait_mode_reg <= `PPMF_RST_MODE_SINGLE0;
    end
    else
    begin
      wb_ack_out      <= bus_req;
      wb_dat_out      <= rd_data;

      port_data_reg   <= port_data_next;
      ta_filt_sel_reg <= ta_filt_sel_next;
      if (wr_port_dir)
        port_dir_reg <= wb_dat_in[4:0];
      if (wr_hold_wait_mode)
        hold_wait_mode_reg <= wb_dat_in[3:0];
      if (wr_tc_filt_sel)
        tc_filt_sel_reg <= wb_dat_in[3:0];
      if (wr_timer_pin_mode)
        timer_pin_mode_reg <= wb_dat_in[4:0];
    end
  end

  // Pin drive and alternate functions
  always @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      clk_div_reg          <= 1'b0;
      port_pin_out         <= 5'h00;
      port_pin_oe_out      <= 5'h00;
      wait_request_out     <= 1'b0;
      bus_hold_request_out <= 1'b0;
    end
    else
    begin
      // Clock out runs at half rate so it can come from a flop
      clk_div_reg <= ~clk_div_reg;

      // Port mode pins show the latch value loaded at this same edge
      port_pin_out[0] <= hold_wait_mode_reg[`PPMF_BIT_WAIT_SEL] ? 1'b0 : port_data_next[0];
      port_pin_out[1] <= hold_wait_mode_reg[`PPMF_BIT_SYSTEM_CLOCK_OUTPUT_SEL] ? ~clk_div_reg
                                                                   : port_data_next[1];
      port_pin_out[2] <= hold_wait_mode_reg[`PPMF_BIT_HOLD_ACK_SEL] ? bus_hold_acknowledge_in
                                                                     : port_data_next[2];
      port_pin_out[3] <= hold_wait_mode_reg[`PPMF_BIT_HOLD_REQ_SEL] ? 1'b0 : port_data_next[3];
      port_pin_out[4] <= port_data_next[4];

      // Control-mode input pins never drive
      port_pin_oe_out[0] <= ~port_dir_reg[0] & ~hold_wait_mode_reg[`PPMF_BIT_WAIT_SEL];
      port_pin_oe_out[1] <= ~port_dir_reg[1];
      port_pin_oe_out[2] <= ~port_dir_reg[2];
      port_pin_oe_out[3] <= ~port_dir_reg[3] & ~hold_wait_mode_reg[`PPMF_BIT_HOLD_REQ_SEL];
      port_pin_oe_out[4] <= ~port_dir_reg[4];
      wait_request_out     <= hold_wait_mode_reg[`PPMF_BIT_WAIT_SEL] & port_pin_in[0];
      bus_hold_request_out <= hold_wait_mode_reg[`PPMF_BIT_HOLD_REQ_SEL] & port_pin_in[3];
    end
  end

  // Interrupt inputs bypass the clock; the delay lives in the pad
  assign external_interrupt_out = external_interrupt_input_in & interrupt_ctrl_mode_in;

  // Sampling ticks; no prescaler tick means no sampling at all
  always @*
  begin
    raw_in = {timer_c_pin_in, timer_a_pin_in};

    case (ta_filt_sel_reg)
      2'h0:    samp_tick[0] = div_tick(timer_ab_prescaler_clock_in, {5'h0, ta_presc_cnt_reg}, 4'h3);
      2'h1:    samp_tick[0] = div_tick(timer_ab_prescaler_clock_in, {5'h0, ta_presc_cnt_reg}, 4'h2);
      2'h2:    samp_tick[0] = div_tick(timer_ab_prescaler_clock_in, {5'h0, ta_presc_cnt_reg}, 4'h1);
      default: samp_tick[0] = timer_ab_prescaler_clock_in;
    endcase
    samp_tick[1] = samp_tick[0];
    samp_tick[2] = samp_tick[0];
    samp_tick[3] = div_tick(timer_c_prescaler_clock_in, tc_presc_cnt_reg,
                            4'h4 - {2'h0, tc_filt_sel_reg[1:0]});
    samp_tick[4] = div_tick(timer_c_prescaler_clock_in, tc_presc_cnt_reg,
                            4'h8 - {2'h0, tc_filt_sel_reg[3:2]});
  end

  // Fourth differing sample in a row accepts the new level
  always @*
  begin
    filt_accept = 5'h00;
    for (m = 0; m < 5; m = m + 1)
    begin
      filt_accept[m] = samp_tick[m] & (raw_in[m] != filt_level_reg[m])
                       & (filt_cnt_reg[m] == `PPMF_FILT_SAMPLES - 3'h1);
    end
  end

  // Timer edge filters
  always @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ta_presc_cnt_reg     <= 3'h0;
      tc_presc_cnt_reg     <= 8'h00;
      filt_level_reg       <= 5'h00;
      timer_a_filtered_out <= 3'h0;
      timer_c_filtered_out <= 2'h0;
      for (k = 0; k < 5; k = k + 1)
        filt_cnt_reg[k] <= 3'h0;
    end
    else
    begin
      if (timer_ab_prescaler_clock_in)
        ta_presc_cnt_reg <= ta_presc_cnt_reg + 3'h1;
      if (timer_c_prescaler_clock_in)
        tc_presc_cnt_reg <= tc_presc_cnt_reg + 8'h01;

      for (k = 0; k < 5; k = k + 1)
      begin
        if (!timer_pin_mode_reg[k])
        begin
          // Port mode: filter idle, output held low
          filt_cnt_reg[k]   <= 3'h0;
          filt_level_reg[k] <= 1'b0;
        end
        else if (samp_tick[k])
        begin
          if (raw_in[k] == filt_level_reg[k])
            filt_cnt_reg[k] <= 3'h0;
          else if (filt_accept[k])
          begin
            filt_cnt_reg[k]   <= 3'h0;
            filt_level_reg[k] <= raw_in[k];
          end
          else
            filt_cnt_reg[k] <= filt_cnt_reg[k] + 3'h1;
        end
      end

      timer_a_filtered_out <= filt_level_reg[2:0];
      timer_c_filtered_out <= filt_level_reg[4:3];
    end
  end

endmodule

// ### testbench/ppmf_props.sv
`timescale 1ns/10ps
module ppmf_props
(
  // Clock and reset
  input wire        mclk_in,
  input wire        srst_in,
  // Bus
  input wire        wb_cyc_in,
  input wire        wb_stb_in,
  input wire        wb_ack_out,
  input wire [31:0] wb_dat_out,
  // Pins
  input wire [4:0]  port_pin_in,
  input wire [4:0]  port_pin_out,
  input wire [4:0]  port_pin_oe_out,
  input wire        wait_request_out,
  input wire        bus_hold_request_out,
  // Interrupts and timers
  input wire [7:0]  external_interrupt_input_in,
  input wire [7:0]  interrupt_ctrl_mode_in,
  input wire [7:0]  external_interrupt_out,
  input wire        timer_ab_prescaler_clock_in,
  input wire [2:0]  timer_a_pin_in,
  input wire [2:0]  timer_a_filtered_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_lat; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:5] == 27'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  property p_irq; external_interrupt_out == (external_interrupt_input_in & interrupt_ctrl_mode_in); endproperty
  a_irq: assert property (p_irq) else $error("interrupt path wrong");
  property p_wait; wait_request_out |-> $past(port_pin_in[0]); endproperty
  a_wait: assert property (p_wait) else $error("wait input wrong");
  property p_hold; bus_hold_request_out |-> $past(port_pin_in[3]); endproperty
  a_hold: assert property (p_hold) else $error("hold request wrong");
  // Reset itself is the antecedent, so no disable here
  property p_rst; disable iff (1'h0) srst_in |=> port_pin_oe_out == 5'h0 && port_pin_out == 5'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins driven in reset");
  property p_filt_val; $changed(timer_a_filtered_out[0]) |-> $past(timer_a_pin_in[0], 2) == timer_a_filtered_out[0];
  endproperty
  a_filt_val: assert property (p_filt_val) else $error("filter took unseen level");
  property p_filt_tick; $changed(timer_a_filtered_out) |-> $past(timer_ab_prescaler_clock_in, 2); endproperty
  a_filt_tick: assert property (p_filt_tick) else $error("filter moved without tick");
  c_read: cover property (wb_ack_out && wb_dat_out != 32'h0);
  c_filt: cover property ($rose(timer_a_filtered_out[0]));
  c_wait: cover property (wait_request_out);
endmodule
bind ppmf_top ppmf_props u_props (.*);

// ### testbench/ppmf_pin_model.sv
`timescale 1ns/10ps
module ppmf_pin_model
(
  // Clock
  input  wire       mclk_in,
  // Device side
  input  wire [4:0] port_pin_out,
  input  wire [4:0] port_pin_oe_out,
  // Far side drive
  input  wire [4:0] ext_drv_in,
  input  wire [4:0] ext_en_in,
  output wire [4:0] port_pin_in
);
  reg [4:0] float_reg = 5'h0A;
  // A released pin holds no level, so keep it moving
  always @(posedge mclk_in) float_reg <= ~float_reg;
  assign port_pin_in = (port_pin_oe_out & port_pin_out) | (~port_pin_oe_out & ext_en_in & ext_drv_in)
                     | (~port_pin_oe_out & ~ext_en_in & float_reg);
endmodule

// ### testbench/port_pin_mode_and_input_filter_test.sv
`timescale 1ns/10ps
module port_pin_mode_and_input_filter_test;
  localparam [31:0] a_dat = 32'hFFFFF00C, a_dir = 32'hFFFFF02C, a_mod = 32'hFFFFF04C, a_ta = 32'h0FFFF5F8;
  localparam [31:0] a_tc = 32'hFFFFF698, a_tpm = 32'hFFFFF6A0, a_bop = 32'hFFFFF6A4;
  reg         mclk_in = 1'h0, srst_in = 1'h1, expanded_mode_strap_in = 1'h0, bus_hold_acknowledge_in = 1'h0;
  reg         wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0, p;
  reg         timer_ab_prescaler_clock_in = 1'h1, timer_c_prescaler_clock_in = 1'h1;
  reg  [31:0] wb_adr_in = 32'h0, wb_dat_in = 32'h0, d, junk;
  reg  [3:0]  wb_sel_in = 4'hF;
  reg  [7:0]  external_interrupt_input_in = 8'hA5, interrupt_ctrl_mode_in = 8'h3C;
  reg  [4:0]  raw = 5'h0, drv = 5'h0, en = 5'h0;
  integer     failures = 0, num_checks = 0, i;
  wire [31:0] wb_dat_out;
  wire        wb_ack_out, wait_request_out, bus_hold_request_out;
  wire [4:0]  port_pin_in, port_pin_out, port_pin_oe_out;
  wire [7:0]  external_interrupt_out;
  wire [2:0]  timer_a_filtered_out, timer_a_pin_in = raw[2:0];
  wire [1:0]  timer_c_filtered_out, timer_c_pin_in = raw[4:3];
  wire [4:0]  outs = {timer_c_filtered_out, timer_a_filtered_out};
  ppmf_top dut (.mclk_in, .srst_in, .expanded_mode_strap_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .port_pin_in, .port_pin_out, .port_pin_oe_out,
    .bus_hold_acknowledge_in, .wait_request_out, .bus_hold_request_out, .external_interrupt_input_in,
    .interrupt_ctrl_mode_in, .external_interrupt_out, .timer_ab_prescaler_clock_in, .timer_c_prescaler_clock_in,
    .timer_a_pin_in, .timer_c_pin_in, .timer_a_filtered_out, .timer_c_filtered_out);
  ppmf_pin_model u_pins (.mclk_in, .port_pin_out, .port_pin_oe_out, .ext_drv_in(drv), .ext_en_in(en), .port_pin_in);
  always #50 mclk_in = ~mclk_in;
  task test_done;
    begin
      if (failures == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] dw, output [31:0] dr);
    begin
      wb_cyc_in <= 1'h1;
      wb_stb_in <= 1'h1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= dw;
      @(posedge mclk_in);
      while (wb_ack_out !== 1'h1) @(posedge mclk_in);
      dr = wb_dat_out;
      wb_cyc_in <= 1'h0;
      wb_stb_in <= 1'h0;
      @(posedge mclk_in);
    end
  endtask
  task wr(input [31:0] a, input [31:0] v); xfer(1'h1, a, v, junk); endtask
  task rd(input [31:0] a); xfer(1'h0, a, 32'h0, d); endtask
  task rst(input s);
    begin
      srst_in <= 1'h1;
      expanded_mode_strap_in <= s;
      repeat (2) @(posedge mclk_in);
      srst_in <= 1'h0;
      @(posedge mclk_in);
    end
  endtask
  // Ticks run every cycle, so the window is four divided ticks plus two edges
  task filt(input [31:0] a, input [31:0] v, input integer dv, input integer ch);
    integer n;
    begin
      wr(a, v);
      raw[ch] <= 1'h1;
      repeat (3 * dv + 2) @(posedge mclk_in);
      chk(outs[ch], 32'h0);
      n = 0;
      while (outs[ch] !== 1'h1 && n < 2 * dv + 2)
      begin
        @(posedge mclk_in);
        n = n + 1;
      end
      chk(outs[ch], 32'h1);
      raw[ch] <= 1'h0;
      repeat (5 * dv + 4) @(posedge mclk_in);
      chk(outs[ch], 32'h0);
    end
  endtask
  initial
  begin
    #1000000;
    failures = failures + 1;
    test_done;
  end
  initial
  begin
    rst(1'h0);
    rd(a_mod); chk(d, 32'h0);
    rd(a_dir); chk(d, 32'h1F);
    rd(a_ta); chk(d, 32'h0);
    wr(32'h0, 32'h5); rd(32'h0); chk(d, 32'h0);
    wr(a_dir, 32'h0); wr(a_dat, 32'h15);
    chk(port_pin_out, 32'h15);
    chk(port_pin_oe_out, 32'h1F);
    rd(a_dat); chk(d, 32'h15);
    wr(a_ta, 32'h3); rd(a_dat); chk(d, 32'h15);
    wr(a_dir, 32'h1F); en <= 5'h1F; drv <= 5'h11; wr(a_dat, 32'h0A);
    chk(port_pin_oe_out, 32'h0);
    rd(a_dat); chk(d, 32'h11);
    en <= 5'h0; wr(a_dir, 32'h0); rd(a_dat); chk(d, 32'h0A);
    wr(a_dat, 32'h1C); wr(a_dir, 32'h3); en <= 5'h3; drv <= 5'h1; wr(a_bop, 32'h210);
    en <= 5'h0; wr(a_dir, 32'h0); rd(a_dat); chk(d, 32'h0D);
    wr(a_mod, 32'hF); bus_hold_acknowledge_in <= 1'h1; en <= 5'h9; drv <= 5'h9;
    repeat (2) @(posedge mclk_in);
    chk(port_pin_oe_out & 5'h9, 32'h0);
    chk(wait_request_out, 32'h1);
    chk(bus_hold_request_out, 32'h1);
    chk(port_pin_out[2], 32'h1);
    p = port_pin_out[1];
    @(posedge mclk_in);
    chk(port_pin_out[1], !p);
    rd(a_dat); chk(d & 32'hD, 32'h4);
    wr(a_dir, 32'h1F); rd(a_dat); chk(d & 32'h9, 32'h9);
    en <= 5'h0;
    external_interrupt_input_in <= 8'h5A;
    @(posedge mclk_in);
    chk(external_interrupt_out, 32'h18);
    rst(1'h1);
    rd(a_mod); chk(d, 32'hF);
    wr(a_bop, 32'h1101); rd(a_ta); chk(d, 32'h1);
    wr(a_bop, 32'h1303); rd(a_ta); chk(d, 32'h2);
    wr(a_tpm, 32'h1F);
    for (i = 0; i < 4; i = i + 1) filt(a_ta, i, 8 >> i, 0);
    for (i = 1; i < 3; i = i + 1) filt(a_ta, 3, 1, i);
    filt(a_tc, 32'h3, 2, 3);
    filt(a_tc, 32'hC, 32, 4);
    timer_ab_prescaler_clock_in <= 1'h0; raw[0] <= 1'h1;
    repeat (30) @(posedge mclk_in);
    chk(outs[0], 32'h0);
    test_done;
  end
endmodule
